// file: dv/decimation_trigger_offset_config_tb_top.sv
`timescale 1ns/1ps

module decimation_trigger_offset_config_tb_top;
  import dtoc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  power_mode_t pmode = MODE_HIGH_PERFORMANCE;
  logic eq_skip = 1'b0;
  logic [1:0] cutoff = 2'h0;
  logic [5:0] rate;
  logic second, filt_en, eq_act, conv;
  logic [2:0] odr;
  logic frame_sync = 1'b0, first_irq = 1'b0, istart = 1'b0;
  logic [2:0] odr_exp;
  logic hv = 1'b0;
  logic signed [HIGHPASS_WIDTH-1:0] hd = '0;
  logic hv_out;
  logic signed [SAMPLE_WIDTH-1:0] hd_out;
  logic sv = 1'b0, s_rdy_out, v_out, rdy = 1'b0;
  sample_t sin = '0;
  sample_t sout;
  int n_fail = 0, check_count = 0, pulses = 0;
  logic [31:0] rd;
  logic [7:0] c;
  logic [19:0] v;
  sample_t exp_q[$];

  always #50 clk = ~clk;
  always @(posedge clk) if (conv === 1'b1) pulses <= pulses + 1;

  decimation_trigger_offset_config DUT (
    .REF_CLK_IN(clk), .RESETN_IN(resetn), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .POWER_MODE_IN(pmode), .EQUALIZER_SKIP_IN(eq_skip),
    .LOW_PASS_CUTOFF_FIELD_IN(cutoff), .FIRST_STAGE_RATE_OUT(rate), .SECOND_STAGE_ACTIVE_OUT(second),
    .ODR_MULTIPLIER_OUT(odr), .FIRST_ORDER_FILTER_ENABLE_OUT(filt_en), .EQUALIZER_ACTIVE_OUT(eq_act),
    .FRAME_SYNC_PIN_IN(frame_sync), .FIRST_INTERRUPT_PIN_IN(first_irq), .INTERNAL_START_IN(istart),
    .CONVERT_START_OUT(conv), .HIGHPASS_VALID_IN(hv), .HIGHPASS_DATA_IN(hd), .HIGHPASS_VALID_OUT(hv_out),
    .HIGHPASS_DATA_OUT(hd_out), .SAMPLE_VALID_IN(sv), .SAMPLE_READY_OUT(s_rdy_out), .SAMPLE_IN(sin),
    .SAMPLE_VALID_OUT(v_out), .SAMPLE_READY_IN(rdy), .SAMPLE_OUT(sout)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("TB: checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // offset is in eighths of an output step, floored
  function automatic logic [15:0] corr(input logic [15:0] x, input logic [7:0] o);
    logic signed [19:0] s;
    s = ($signed({{4{x[15]}}, x}) * 20'sd8 + $signed({{12{o[7]}}, o})) >>> 3;
    if (s > 20'sd32767) return 16'h7fff;
    if (s < -20'sd32768) return 16'h8000;
    return s[15:0];
  endfunction : corr

  task automatic trig(input logic [7:0] cfg);
    bus(1'b1, ADDR_TRIGGER_FILTER_CONFIG, {24'h0, cfg});
    @(negedge clk);
    pulses = 0;
    @(posedge clk);
    // internal pulse in every mode, so external mode must show it is ignored
    istart <= 1'b1;
    @(posedge clk);
    istart <= 1'b0;
    frame_sync <= 1'b1;
    repeat (3) @(posedge clk);
    frame_sync <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pulses, (cfg[1:0] == 2'h3) ? 32'h0 : 32'h1, "start after frame sync");
    first_irq <= 1'b1;
    repeat (3) @(posedge clk);
    first_irq <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pulses, 1, "start count");
    $display("test trigger %h done", cfg);
  endtask : trig

  // fills the buffer until it refuses, then drains with random stalls
  task automatic fifo_run(input power_mode_t m);
    sample_t w;
    sample_t e;
    logic [7:0] xo;
    logic [7:0] yo;
    pmode <= m;
    // eight eighths make one whole output step
    xo = (m == MODE_ULTRA_LOW_POWER) ? 8'h08 : 8'($urandom);
    yo = 8'($urandom);
    bus(1'b1, ADDR_X_LOW_POWER_OFFSET, {24'h0, xo});
    bus(1'b1, ADDR_Y_LOW_POWER_OFFSET, {24'h0, yo});
    bus(1'b0, ADDR_X_LOW_POWER_OFFSET, 32'h0);
    chk(rd, {24'h0, xo}, "x offset");
    bus(1'b0, ADDR_Y_LOW_POWER_OFFSET, 32'h0);
    chk(rd, {24'h0, yo}, "y offset");
    for (int i = 0; i < 16; i++)
    begin
      w = $urandom;
      if (i == 0) w = {16'h8000, 16'h7fff};
      if (i == 1) w = {16'h7fff, 16'h8000};
      e = w;
      if (m inside {MODE_ULTRA_LOW_POWER, MODE_VERY_LOW_POWER, MODE_HIGH_SPEED}) e = {corr(w.y, yo), corr(w.x, xo)};
      exp_q.push_back(e);
      sv <= 1'b1;
      sin <= w;
      @(posedge clk);
    end
    sin <= ~w;
    @(negedge clk);
    chk(s_rdy_out, 32'h0, "full");
    @(posedge clk);
    sv <= 1'b0;
    bus(1'b0, ADDR_PATH_STATUS, 32'h0);
    chk(rd[20:16], FIFO_DEPTH, "level");
    for (int k = 0; k < 300 && exp_q.size() > 0; k++)
    begin
      @(negedge clk);
      if (v_out === 1'b1 && rdy === 1'b1)
      begin
        e = exp_q.pop_front();
        chk(sout, e, "sample");
      end
      @(posedge clk);
      rdy <= (exp_q.size() > 0) && 1'($urandom);
    end
    @(negedge clk);
    chk(v_out, 32'h0, "empty");
    chk(exp_q.size(), 0, "drained");
    $display("test samples mode %h done", m);
  endtask : fifo_run

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h42b9));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_TRIGGER_FILTER_CONFIG, 32'h0);
    chk(rd, 32'h0, "cfg reset");
    bus(1'b0, ADDR_X_LOW_POWER_OFFSET, 32'h0);
    chk(rd, 32'h0, "x reset");
    bus(1'b0, ADDR_Y_LOW_POWER_OFFSET, 32'h0);
    chk(rd, 32'h0, "y reset");
    chk({rate, second, odr, filt_en, hresp}, {6'h20, 1'b1, 3'h1, 2'h0}, "reset outs");
    bus(1'b0, 32'h0000_0100, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      c = {3'(i), 5'($urandom)};
      eq_skip <= c[5] | 1'($urandom);
      cutoff <= c[5] ? 2'h0 : 2'($urandom);
      bus(1'b1, ADDR_TRIGGER_FILTER_CONFIG, {24'hffffff, c});
      bus(1'b0, ADDR_TRIGGER_FILTER_CONFIG, 32'h0);
      chk(rd, {24'h0, c & 8'he7}, "cfg read");
      @(negedge clk);
      chk(rate, c[6] ? 6'h10 : 6'h20, "rate");
      chk(second, !c[6] && !c[7], "second");
      chk(odr, c[6] ? 3'h4 : (c[7] ? 3'h2 : 3'h1), "odr");
      chk(filt_en, c[5], "filter");
      chk(eq_act, !eq_skip && !c[5], "equalizer");
      @(posedge clk);
      odr_exp = c[6] ? 3'h4 : (c[7] ? 3'h2 : 3'h1);
      bus(1'b0, ADDR_PATH_STATUS, 32'h0);
      chk(rd, {21'h0, odr_exp, 4'h0, c[5], !eq_skip && !c[5], c[6], !c[6] && !c[7]}, "status");
    end
    $display("test config done");
    for (int r = 0; r < 2; r++)
    begin
      bus(1'b1, ADDR_TRIGGER_FILTER_CONFIG, {29'h0, 1'(r), 2'h0});
      for (int j = 0; j < 10; j++)
      begin
        v = (j == 0) ? 20'h80000 : ((j == 1) ? 20'h7ffff : 20'($urandom));
        hv <= 1'b1;
        hd <= v;
        @(posedge clk);
        hv <= 1'b0;
        @(negedge clk);
        chk(hv_out, 32'h1, "highpass valid");
        chk($unsigned(hd_out), 16'(v[19:4] + {15'h0, 1'(r) & v[19]}), "highpass data");
        @(posedge clk);
      end
    end
    $display("test rounding done");
    trig(8'h00);
    trig(8'h02);
    trig(8'h01);
    trig(8'h03);
    fifo_run(MODE_ULTRA_LOW_POWER);
    fifo_run(MODE_VERY_LOW_POWER);
    fifo_run(MODE_HIGH_SPEED);
    fifo_run(MODE_HIGH_PERFORMANCE);
    fifo_run(MODE_REDUCED_BANDWIDTH);
    fifo_run(MODE_LOW_POWER);
    report_and_stop();
  end

endmodule : decimation_trigger_offset_config_tb_top

// file: rtl/decimation_trigger_offset_config.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // fill side
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [WIDTH-1:0] push_data_in,
  // drain side
  output logic pop_valid_out,
  input wire logic pop_ready_in,
  output logic [WIDTH-1:0] pop_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign push_ready_out = (count != (PW+1)'(DEPTH));
  assign pop_valid_out = (count != '0);
  assign push = push_valid_in && push_ready_out;
  assign pop = pop_valid_out && pop_ready_in;
  assign pop_data_out = mem[rd_ptr];
  assign level_out = count;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : sample_fifo

module decimation_trigger_offset_config
  import dtoc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // operating context
  input wire power_mode_t POWER_MODE_IN,
  input wire logic EQUALIZER_SKIP_IN,
  input wire logic [1:0] LOW_PASS_CUTOFF_FIELD_IN,
  // decimation and filter control
  output logic [5:0] FIRST_STAGE_RATE_OUT,
  output logic SECOND_STAGE_ACTIVE_OUT,
  output logic [2:0] ODR_MULTIPLIER_OUT,
  output logic FIRST_ORDER_FILTER_ENABLE_OUT,
  output logic EQUALIZER_ACTIVE_OUT,
  // conversion start
  input wire logic FRAME_SYNC_PIN_IN,
  input wire logic FIRST_INTERRUPT_PIN_IN,
  input wire logic INTERNAL_START_IN,
  output logic CONVERT_START_OUT,
  // high-pass output reduction
  input wire logic HIGHPASS_VALID_IN,
  input wire logic signed [HIGHPASS_WIDTH-1:0] HIGHPASS_DATA_IN,
  output logic HIGHPASS_VALID_OUT,
  output logic signed [SAMPLE_WIDTH-1:0] HIGHPASS_DATA_OUT,
  // low-power sample stream
  input wire logic SAMPLE_VALID_IN,
  output logic SAMPLE_READY_OUT,
  input wire sample_t SAMPLE_IN,
  output logic SAMPLE_VALID_OUT,
  input wire logic SAMPLE_READY_IN,
  output sample_t SAMPLE_OUT
);
  // ------------------------------------------------------------
  // register file over ahb-lite
  // ------------------------------------------------------------
  trigger_filter_config_t trigger_filter_config;
  trigger_filter_config_t next_config;
  logic [7:0] x_low_power_offset;
  logic [7:0] y_low_power_offset;
  logic [7:0] next_x_offset;
  logic [7:0] next_y_offset;
  logic wr_pending;
  logic [31:0] wr_addr;
  logic accept;
  logic [31:0] read_value;
  logic [31:0] status_word;
  logic [4:0] fifo_level;

  assign accept = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  // zero wait states: every transfer completes in its first data-phase cycle
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      wr_pending <= 1'b0;
      wr_addr <= 32'h00000000;
    end
    else
    begin
      wr_pending <= accept && HWRITE_IN;
      wr_addr <= {HADDR_IN[31:2], 2'h0};
    end
  end

  always_comb
  begin
    next_config = trigger_filter_config;
    next_x_offset = x_low_power_offset;
    next_y_offset = y_low_power_offset;
    if (wr_pending && wr_addr == ADDR_TRIGGER_FILTER_CONFIG)
    begin
      next_config = HWDATA_IN[7:0] & CONFIG_WRITE_MASK;
    end
    if (wr_pending && wr_addr == ADDR_X_LOW_POWER_OFFSET)
    begin
      next_x_offset = HWDATA_IN[7:0];
    end
    if (wr_pending && wr_addr == ADDR_Y_LOW_POWER_OFFSET)
    begin
      next_y_offset = HWDATA_IN[7:0];
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      trigger_filter_config <= RESET_TRIGGER_FILTER_CONFIG;
      x_low_power_offset <= RESET_LOW_POWER_OFFSET;
      y_low_power_offset <= RESET_LOW_POWER_OFFSET;
    end
    else
    begin
      trigger_filter_config <= next_config;
      x_low_power_offset <= next_x_offset;
      y_low_power_offset <= next_y_offset;
    end
  end

  assign status_word = {11'h000, fifo_level, 5'h00, ODR_MULTIPLIER_OUT, 4'h0,
                        FIRST_ORDER_FILTER_ENABLE_OUT, EQUALIZER_ACTIVE_OUT,
                        trigger_filter_config.first_stage_rate_select, SECOND_STAGE_ACTIVE_OUT};

  // read mux sees pending write data, so a back-to-back read of the config or offset registers is never stale; path status is not
  always_comb
  begin
    read_value = 32'h00000000;
    case ({HADDR_IN[31:2], 2'h0})
      ADDR_TRIGGER_FILTER_CONFIG: read_value = {24'h000000, next_config};
      ADDR_X_LOW_POWER_OFFSET: read_value = {24'h000000, next_x_offset};
      ADDR_Y_LOW_POWER_OFFSET: read_value = {24'h000000, next_y_offset};
      ADDR_PATH_STATUS: read_value = status_word;
      default: read_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      HRDATA_OUT <= 32'h00000000;
    end
    else if (accept && !HWRITE_IN)
    begin
      HRDATA_OUT <= read_value;
    end
  end

  // ------------------------------------------------------------
  // decimation chain and filter selection
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      FIRST_STAGE_RATE_OUT <= FIRST_STAGE_SLOW;
      SECOND_STAGE_ACTIVE_OUT <= 1'b1;
      ODR_MULTIPLIER_OUT <= ODR_BASE;
    end
    else if (trigger_filter_config.first_stage_rate_select)
    begin
      FIRST_STAGE_RATE_OUT <= FIRST_STAGE_FAST;
      SECOND_STAGE_ACTIVE_OUT <= 1'b0;
      ODR_MULTIPLIER_OUT <= ODR_QUAD;
    end
    else
    begin
      FIRST_STAGE_RATE_OUT <= FIRST_STAGE_SLOW;
      SECOND_STAGE_ACTIVE_OUT <= !trigger_filter_config.second_stage_skip;
      ODR_MULTIPLIER_OUT <= trigger_filter_config.second_stage_skip ? ODR_DOUBLE : ODR_BASE;
    end
  end

  // cutoff field and equalizer skip are trusted to software; no interlock here
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      FIRST_ORDER_FILTER_ENABLE_OUT <= 1'b0;
      EQUALIZER_ACTIVE_OUT <= 1'b0;
    end
    else
    begin
      FIRST_ORDER_FILTER_ENABLE_OUT <= trigger_filter_config.first_order_filter_enable;
      EQUALIZER_ACTIVE_OUT <= (POWER_MODE_IN == MODE_HIGH_PERFORMANCE) && !EQUALIZER_SKIP_IN
                              && !trigger_filter_config.first_order_filter_enable;
    end
  end

  // ------------------------------------------------------------
  // conversion start
  // ------------------------------------------------------------
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [1:0] pin_rise;
  logic selected_rise;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end
    else
    begin
      pin_meta <= {FIRST_INTERRUPT_PIN_IN, FRAME_SYNC_PIN_IN};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev;
  assign selected_rise = trigger_filter_config.trigger_pin_select ? pin_rise[1] : pin_rise[0];

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      CONVERT_START_OUT <= 1'b0;
    end
    else if (trigger_filter_config.external_trigger_enable)
    begin
      CONVERT_START_OUT <= selected_rise;
    end
    else
    begin
      CONVERT_START_OUT <= INTERNAL_START_IN;
    end
  end

  // ------------------------------------------------------------
  // high-pass output reduction
  // ------------------------------------------------------------
  logic signed [SAMPLE_WIDTH-1:0] highpass_cut;
  assign highpass_cut = HIGHPASS_DATA_IN[HIGHPASS_WIDTH-1 -: SAMPLE_WIDTH];

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      HIGHPASS_VALID_OUT <= 1'b0;
      HIGHPASS_DATA_OUT <= 16'h0000;
    end
    else
    begin
      HIGHPASS_VALID_OUT <= HIGHPASS_VALID_IN;
      if (HIGHPASS_VALID_IN)
      begin
        // a negative cut value plus one never overflows
        if (trigger_filter_config.floor_round_enable && HIGHPASS_DATA_IN[HIGHPASS_WIDTH-1])
        begin
          HIGHPASS_DATA_OUT <= highpass_cut + 16'h0001;
        end
        else
        begin
          HIGHPASS_DATA_OUT <= highpass_cut;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // low-power offset correction and buffering
  // ------------------------------------------------------------
  logic low_power_path;
  logic [15:0] axis_in [2];
  logic [15:0] axis_out [2];
  logic [7:0] axis_offset [2];
  sample_t corrected;

  assign low_power_path = (POWER_MODE_IN == MODE_ULTRA_LOW_POWER) || (POWER_MODE_IN == MODE_VERY_LOW_POWER)
                          || (POWER_MODE_IN == MODE_HIGH_SPEED);
  assign axis_in[0] = SAMPLE_IN.x;
  assign axis_in[1] = SAMPLE_IN.y;
  assign axis_offset[0] = x_low_power_offset;
  assign axis_offset[1] = y_low_power_offset;

  // fractional offset steps below one output step are floored away
  for (genvar a = 0; a < 2; a++)
  begin : g_axis
    logic signed [19:0] scaled_sum;
    logic signed [16:0] whole;
    assign scaled_sum = $signed({axis_in[a][15], axis_in[a], 3'h0})
                        + $signed({{12{axis_offset[a][7]}}, axis_offset[a]});
    assign whole = 17'(scaled_sum >>> OFFSET_FRAC_BITS);
    always_comb
    begin
      if (!low_power_path)
      begin
        axis_out[a] = axis_in[a];
      end
      else if (whole > SAT_MAX)
      begin
        axis_out[a] = SAT_MAX[15:0];
      end
      else if (whole < SAT_MIN)
      begin
        axis_out[a] = SAT_MIN[15:0];
      end
      else
      begin
        axis_out[a] = whole[15:0];
      end
    end
  end

  assign corrected = {axis_out[1], axis_out[0]};

  sample_fifo #(
    .WIDTH($bits(sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .push_valid_in(SAMPLE_VALID_IN),
    .push_ready_out(SAMPLE_READY_OUT),
    .push_data_in(corrected),
    .pop_valid_out(SAMPLE_VALID_OUT),
    .pop_ready_in(SAMPLE_READY_IN),
    .pop_data_out(SAMPLE_OUT),
    .level_out(fifo_level)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  skip_second_a:
    assert property (trigger_filter_config.second_stage_skip && !trigger_filter_config.first_stage_rate_select
                     |=> !SECOND_STAGE_ACTIVE_OUT && ODR_MULTIPLIER_OUT == ODR_DOUBLE)
    else $error("skip bit did not drop second stage");
  slow_rate_a:
    assert property (!trigger_filter_config.first_stage_rate_select
                     |=> FIRST_STAGE_RATE_OUT == FIRST_STAGE_SLOW
                         && SECOND_STAGE_ACTIVE_OUT == !$past(trigger_filter_config.second_stage_skip))
    else $error("slow first stage wrong");
  fast_rate_a:
    assert property (trigger_filter_config.first_stage_rate_select
                     |=> FIRST_STAGE_RATE_OUT == FIRST_STAGE_FAST && !SECOND_STAGE_ACTIVE_OUT
                         && ODR_MULTIPLIER_OUT == ODR_QUAD)
    else $error("fast first stage wrong");
  iir_follow_a:
    assert property (##1 FIRST_ORDER_FILTER_ENABLE_OUT == $past(trigger_filter_config.first_order_filter_enable))
    else $error("first-order filter enable lags");
  truncate_out_a:
    assert property (HIGHPASS_VALID_IN && !trigger_filter_config.floor_round_enable
                     |=> HIGHPASS_VALID_OUT && HIGHPASS_DATA_OUT == $past(highpass_cut))
    else $error("truncation result wrong");
  floor_round_a:
    assert property (HIGHPASS_VALID_IN && trigger_filter_config.floor_round_enable && HIGHPASS_DATA_IN[19]
                     |=> HIGHPASS_DATA_OUT == $past(highpass_cut) + 16'h0001)
    else $error("negative rounding wrong");
  pin_trigger_a:
    assert property (trigger_filter_config.external_trigger_enable && selected_rise |=> CONVERT_START_OUT)
    else $error("external edge missed");
  pin_choice_a:
    assert property (trigger_filter_config.external_trigger_enable && !trigger_filter_config.trigger_pin_select
                     && !pin_rise[0] |=> !CONVERT_START_OUT)
    else $error("unselected pin started conversion");
  internal_start_a:
    assert property (!trigger_filter_config.external_trigger_enable
                     |=> CONVERT_START_OUT == $past(INTERNAL_START_IN))
    else $error("internal start not followed");
  config_reset_a:
    assert property ($rose(RESETN_IN) |-> trigger_filter_config == RESET_TRIGGER_FILTER_CONFIG)
    else $error("configuration not zero after reset");
  reserved_zero_a:
    assert property (trigger_filter_config.reserved == 2'h0)
    else $error("reserved bits not zero");
  equalizer_off_a:
    assert property (POWER_MODE_IN != MODE_HIGH_PERFORMANCE |=> !EQUALIZER_ACTIVE_OUT)
    else $error("equalizer active outside high-performance mode");
  offset_step_a:
    assert property (low_power_path && x_low_power_offset == 8'h08 && SAMPLE_IN.x != 16'sh7fff
                     |-> corrected.x == SAMPLE_IN.x + 16'sh0001)
    else $error("eight offset steps not one output step");
  offset_bypass_a:
    assert property (!low_power_path |-> corrected == SAMPLE_IN)
    else $error("offset applied outside low-power path");
endmodule : decimation_trigger_offset_config

// file: rtl/dtoc_pkg.sv
package dtoc_pkg;

  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_TRIGGER_FILTER_CONFIG = 8'h49;
  localparam logic [7:0] IDX_X_LOW_POWER_OFFSET = 8'h4a;
  localparam logic [7:0] IDX_Y_LOW_POWER_OFFSET = 8'h4b;
  localparam logic [7:0] IDX_PATH_STATUS = 8'h60;
  localparam logic [31:0] ADDR_TRIGGER_FILTER_CONFIG = {22'h000000, IDX_TRIGGER_FILTER_CONFIG, 2'h0};
  localparam logic [31:0] ADDR_X_LOW_POWER_OFFSET = {22'h000000, IDX_X_LOW_POWER_OFFSET, 2'h0};
  localparam logic [31:0] ADDR_Y_LOW_POWER_OFFSET = {22'h000000, IDX_Y_LOW_POWER_OFFSET, 2'h0};
  localparam logic [31:0] ADDR_PATH_STATUS = {22'h000000, IDX_PATH_STATUS, 2'h0};

  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_TRIGGER_FILTER_CONFIG = 8'h00;
  localparam logic [7:0] RESET_LOW_POWER_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'he7;

  // ------------------------------------------------------------
  // datapath sizes and rates
  // ------------------------------------------------------------
  localparam int SAMPLE_WIDTH = 16;
  localparam int HIGHPASS_WIDTH = 20;
  localparam int OFFSET_FRAC_BITS = 3;
  localparam int FIFO_DEPTH = 16;
  localparam logic [5:0] FIRST_STAGE_SLOW = 6'h20;
  localparam logic [5:0] FIRST_STAGE_FAST = 6'h10;
  localparam logic [2:0] ODR_BASE = 3'h1;
  localparam logic [2:0] ODR_DOUBLE = 3'h2;
  localparam logic [2:0] ODR_QUAD = 3'h4;
  localparam logic signed [16:0] SAT_MAX = 17'sh07fff;
  localparam logic signed [16:0] SAT_MIN = -17'sh08000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_ULTRA_LOW_POWER = 6'h01,
    MODE_VERY_LOW_POWER = 6'h02,
    MODE_HIGH_SPEED = 6'h04,
    MODE_HIGH_PERFORMANCE = 6'h08,
    MODE_REDUCED_BANDWIDTH = 6'h10,
    MODE_LOW_POWER = 6'h20
  } power_mode_t;

  typedef struct packed {
    logic second_stage_skip;
    logic first_stage_rate_select;
    logic first_order_filter_enable;
    logic [1:0] reserved;
    logic floor_round_enable;
    logic trigger_pin_select;
    logic external_trigger_enable;
  } trigger_filter_config_t;

  typedef struct packed {
    logic signed [15:0] y;
    logic signed [15:0] x;
  } sample_t;

endpackage : dtoc_pkg
